// file: dee_logger.sv
// ECC error logger: first/next error registers, message routing, Avalon slave
`default_nettype none
module dee_logger
	import dee_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire dee_err_t ecc_err,
	output dee_msg_t msg_ff
);
	// ==========================================================================
	// Bus decode
	// ==========================================================================
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] idx);
		hit = (a == {idx, WORD_LO});
	endfunction

	function automatic logic [FLAG_W-1:0] pack_err(input dee_err_t e);
		pack_err = {e.uncorr, e.corr};
	endfunction

	dee_bus_st_t st_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic wait_ff;
	logic [FLAG_W-1:0] first_ff;
	logic [FLAG_W-1:0] next_ff;
	logic [FLAG_W-1:0] ena_ctrl_ff;
	logic [FLAG_W-1:0] ena_mgmt_ff;
	logic [FLAG_W-1:0] ena_serr_ff;
	logic [FLAG_W-1:0] nxt_first;
	logic [FLAG_W-1:0] nxt_next;
	logic [FLAG_W-1:0] err_in;
	logic [FLAG_W-1:0] rise;
	logic wr_acc;
	logic lane0;
	logic [FLAG_W-1:0] clr_first;
	logic [FLAG_W-1:0] clr_next;

	// Access completes in the answer state; one wait cycle always
	assign wr_acc = (st_ff == ST_ANSWER) && avs_write;
	assign lane0 = avs_byteenable[0];
	assign err_in = pack_err(ecc_err);
	assign clr_first = (wr_acc && lane0 && hit(avs_address, REG_FIRST_IDX)) ?
		avs_writedata[FLAG_W-1:0] : FLAGS_RST;
	assign clr_next = (wr_acc && lane0 && hit(avs_address, REG_NEXT_IDX)) ?
		avs_writedata[FLAG_W-1:0] : FLAGS_RST;

	// ==========================================================================
	// Bus handshake
	// ==========================================================================
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_ff <= ST_IDLE;
		end else begin
			case (st_ff)
				ST_IDLE: begin
					if (avs_read || avs_write) begin
						st_ff <= ST_ANSWER;
					end
				end
				ST_ANSWER: st_ff <= ST_IDLE;
				default: st_ff <= ST_IDLE;
			endcase
		end
	end

	// Waitrequest high at idle while a request is pending, low in answer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wait_ff <= 1'b1;
		end else begin
			wait_ff <= !((st_ff == ST_IDLE) && (avs_read || avs_write));
		end
	end
	assign avs_waitrequest = wait_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_ff <= RDATA_RST;
		end else if ((st_ff == ST_IDLE) && avs_read) begin
			rdata_ff <= UNMAPPED_RD;
			if (hit(avs_address, REG_FIRST_IDX)) begin
				rdata_ff[FLAG_W-1:0] <= first_ff;
			end else if (hit(avs_address, REG_NEXT_IDX)) begin
				rdata_ff[FLAG_W-1:0] <= next_ff;
			end else if (hit(avs_address, REG_CTRL_EV_IDX)) begin
				rdata_ff[FLAG_W-1:0] <= ena_ctrl_ff;
			end else if (hit(avs_address, REG_MGMT_EV_IDX)) begin
				rdata_ff[FLAG_W-1:0] <= ena_mgmt_ff;
			end else if (hit(avs_address, REG_SERR_IDX)) begin
				rdata_ff[FLAG_W-1:0] <= ena_serr_ff;
			end
		end
	end
	assign avs_readdata = rdata_ff;

	// ==========================================================================
	// Enable registers
	// ==========================================================================
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ena_ctrl_ff <= ENA_RST;
			ena_mgmt_ff <= ENA_RST;
			ena_serr_ff <= ENA_RST;
		end else if (wr_acc && lane0) begin
			if (hit(avs_address, REG_CTRL_EV_IDX)) begin
				ena_ctrl_ff <= avs_writedata[FLAG_W-1:0];
			end
			if (hit(avs_address, REG_MGMT_EV_IDX)) begin
				ena_mgmt_ff <= avs_writedata[FLAG_W-1:0];
			end
			if (hit(avs_address, REG_SERR_IDX)) begin
				ena_serr_ff <= avs_writedata[FLAG_W-1:0];
			end
		end
	end

	// ==========================================================================
	// Error logging
	// ==========================================================================
	// Capture only when empty; a new error wins over a same-cycle clear in next, not in first
	always_comb begin
		nxt_first = first_ff & ~clr_first;
		if (first_ff == FLAGS_RST) begin
			nxt_first = err_in;
		end
	end

	always_comb begin
		nxt_next = next_ff & ~clr_next;
		if (first_ff != FLAGS_RST) begin
			nxt_next = nxt_next | err_in | next_ff & ~clr_next;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			first_ff <= FLAGS_RST;
			next_ff <= FLAGS_RST;
		end else begin
			first_ff <= nxt_first;
			next_ff <= nxt_next;
		end
	end

	// ==========================================================================
	// Message routing
	// ==========================================================================
	assign rise = (nxt_first & ~first_ff) | (nxt_next & ~next_ff);

	// Software keeps one kind per flag; the outputs stay independent
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			msg_ff <= '0;
		end else begin
			msg_ff.ctrl_ev <= |(rise & ena_ctrl_ff);
			msg_ff.mgmt_ev <= |(rise & ena_mgmt_ff);
			msg_ff.serr <= |(rise & ena_serr_ff);
		end
	end

	// ==========================================================================
	// Checks
	// ==========================================================================
	sequence empty_err_s;
		first_ff == FLAGS_RST && err_in != FLAGS_RST;
	endsequence

	sequence held_err_s;
		first_ff != FLAGS_RST && err_in != FLAGS_RST;
	endsequence

	first_capture_a: assert property (@(posedge mclk) disable iff (rst)
		empty_err_s |=> first_ff == $past(err_in))
		else $error("first error not captured");

	first_hold_a: assert property (@(posedge mclk) disable iff (rst)
		first_ff != FLAGS_RST && clr_first == FLAGS_RST |=>
		first_ff == $past(first_ff))
		else $error("first error changed while held");

	first_noadd_a: assert property (@(posedge mclk) disable iff (rst)
		first_ff != FLAGS_RST |=> (first_ff & ~$past(first_ff)) == FLAGS_RST)
		else $error("flag added to held first error");

	next_set_a: assert property (@(posedge mclk) disable iff (rst)
		held_err_s |=> (next_ff & $past(err_in)) == $past(err_in))
		else $error("next error not set");

	next_accum_a: assert property (@(posedge mclk) disable iff (rst)
		first_ff != FLAGS_RST && clr_next == FLAGS_RST |=>
		(next_ff & $past(next_ff)) == $past(next_ff))
		else $error("next error lost a flag");

	w1c_clear_a: assert property (@(posedge mclk) disable iff (rst)
		clr_next != FLAGS_RST && first_ff == FLAGS_RST |=>
		(next_ff & $past(clr_next)) == FLAGS_RST)
		else $error("write one did not clear");

	ctrl_event_a: assert property (@(posedge mclk) disable iff (rst)
		(rise & ena_ctrl_ff) != FLAGS_RST |=> msg_ff.ctrl_ev)
		else $error("control event missing");

	mgmt_event_a: assert property (@(posedge mclk) disable iff (rst)
		(rise & ena_mgmt_ff) != FLAGS_RST |=> msg_ff.mgmt_ev)
		else $error("management event missing");

	serr_event_a: assert property (@(posedge mclk) disable iff (rst)
		(rise & ena_serr_ff) != FLAGS_RST |=> msg_ff.serr)
		else $error("system error missing");

	msg_once_a: assert property (@(posedge mclk) disable iff (rst)
		msg_ff.serr && rise == FLAGS_RST |=> !msg_ff.serr)
		else $error("message repeated");

	bus_wait_a: assert property (@(posedge mclk) disable iff (rst)
		st_ff == ST_IDLE && (avs_read || avs_write) |=> !avs_waitrequest)
		else $error("bus answer late");

	sequence bus_req_s;
		st_ff == ST_IDLE && (avs_read || avs_write);
	endsequence

	sequence bus_ans_s;
		st_ff == ST_ANSWER && !avs_waitrequest;
	endsequence

	bus_answer_a: assert property (@(posedge mclk) disable iff (rst)
		bus_req_s |=> bus_ans_s)
		else $error("bus answer state missing");

	bus_release_a: assert property (@(posedge mclk) disable iff (rst)
		st_ff == ST_ANSWER |=> st_ff == ST_IDLE && avs_waitrequest)
		else $error("bus not released after answer");

	wait_idle_a: assert property (@(posedge mclk) disable iff (rst)
		st_ff == ST_IDLE |-> avs_waitrequest)
		else $error("waitrequest low while idle");

	rd_first_a: assert property (@(posedge mclk) disable iff (rst)
		st_ff == ST_IDLE && avs_read &&
		hit(avs_address, REG_FIRST_IDX) |=>
		avs_readdata[FLAG_W-1:0] == $past(first_ff))
		else $error("first error read back wrong");

	rd_next_a: assert property (@(posedge mclk) disable iff (rst)
		st_ff == ST_IDLE && avs_read &&
		hit(avs_address, REG_NEXT_IDX) |=>
		avs_readdata[FLAG_W-1:0] == $past(next_ff))
		else $error("next error read back wrong");

	rd_ctrl_a: assert property (@(posedge mclk) disable iff (rst)
		st_ff == ST_IDLE && avs_read &&
		hit(avs_address, REG_CTRL_EV_IDX) |=>
		avs_readdata[FLAG_W-1:0] == $past(ena_ctrl_ff))
		else $error("control enable read back wrong");

	rd_mgmt_a: assert property (@(posedge mclk) disable iff (rst)
		st_ff == ST_IDLE && avs_read &&
		hit(avs_address, REG_MGMT_EV_IDX) |=>
		avs_readdata[FLAG_W-1:0] == $past(ena_mgmt_ff))
		else $error("management enable read back wrong");

	rd_serr_a: assert property (@(posedge mclk) disable iff (rst)
		st_ff == ST_IDLE && avs_read &&
		hit(avs_address, REG_SERR_IDX) |=>
		avs_readdata[FLAG_W-1:0] == $past(ena_serr_ff))
		else $error("system error enable read back wrong");

	rd_upper_a: assert property (@(posedge mclk) disable iff (rst)
		st_ff == ST_IDLE && avs_read |=>
		avs_readdata[DATA_W-1:FLAG_W] == '0)
		else $error("upper read data not zero");

	ctrl_write_a: assert property (@(posedge mclk) disable iff (rst)
		wr_acc && lane0 && hit(avs_address, REG_CTRL_EV_IDX) |=>
		ena_ctrl_ff == $past(avs_writedata[FLAG_W-1:0]))
		else $error("control enable not written");

	mgmt_write_a: assert property (@(posedge mclk) disable iff (rst)
		wr_acc && lane0 && hit(avs_address, REG_MGMT_EV_IDX) |=>
		ena_mgmt_ff == $past(avs_writedata[FLAG_W-1:0]))
		else $error("management enable not written");

	serr_write_a: assert property (@(posedge mclk) disable iff (rst)
		wr_acc && lane0 && hit(avs_address, REG_SERR_IDX) |=>
		ena_serr_ff == $past(avs_writedata[FLAG_W-1:0]))
		else $error("system error enable not written");

	ena_keep_a: assert property (@(posedge mclk) disable iff (rst)
		!(wr_acc && lane0) |=> $stable(ena_ctrl_ff) &&
		$stable(ena_mgmt_ff) && $stable(ena_serr_ff))
		else $error("enable changed without write");

	first_clear_a: assert property (@(posedge mclk) disable iff (rst)
		clr_first != FLAGS_RST && first_ff != FLAGS_RST |=>
		(first_ff & $past(clr_first)) == FLAGS_RST)
		else $error("first error not cleared by one");

	next_empty_a: assert property (@(posedge mclk) disable iff (rst)
		first_ff == FLAGS_RST && clr_next == FLAGS_RST |=>
		next_ff == $past(next_ff))
		else $error("next error set while first empty");

	reset_clear_a: assert property (@(posedge mclk)
		rst |-> first_ff == FLAGS_RST && next_ff == FLAGS_RST)
		else $error("error flags not cleared by reset");

	reset_out_a: assert property (@(posedge mclk)
		rst |-> avs_waitrequest && msg_ff == '0 &&
		avs_readdata == RDATA_RST)
		else $error("outputs not idle in reset");

	ctrl_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		(rise & ena_ctrl_ff) == FLAGS_RST |=> !msg_ff.ctrl_ev)
		else $error("control event without cause");

	mgmt_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		(rise & ena_mgmt_ff) == FLAGS_RST |=> !msg_ff.mgmt_ev)
		else $error("management event without cause");

	serr_quiet_a: assert property (@(posedge mclk) disable iff (rst)
		(rise & ena_serr_ff) == FLAGS_RST |=> !msg_ff.serr)
		else $error("system error without cause");

	ctrl_once_a: assert property (@(posedge mclk) disable iff (rst)
		msg_ff.ctrl_ev && rise == FLAGS_RST |=> !msg_ff.ctrl_ev)
		else $error("control event repeated");

	mgmt_once_a: assert property (@(posedge mclk) disable iff (rst)
		msg_ff.mgmt_ev && rise == FLAGS_RST |=> !msg_ff.mgmt_ev)
		else $error("management event repeated");
endmodule
`default_nettype wire

// file: dee_logger_test.sv
// Self-checking testbench for the ECC error logger
`default_nettype none
module dee_logger_test import dee_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Signals and instance
	// ==========================================================
	logic mclk;
	logic rst;
	logic [ADDR_W-1:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [DATA_W-1:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [DATA_W-1:0] avs_readdata;
	logic avs_waitrequest;
	dee_err_t ecc_err;
	dee_msg_t msg_ff;
	int err_total;
	int cmp_count;
	int pc[3];
	function automatic logic [7:0] ena_idx(input int k);
		ena_idx = (k == 0) ? REG_CTRL_EV_IDX :
			(k == 1) ? REG_MGMT_EV_IDX : REG_SERR_IDX;
	endfunction
	dee_logger dut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ecc_err(ecc_err), .msg_ff(msg_ff));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Pulse counters, one per message kind
	always @(posedge mclk) begin
		for (int i = 0; i < 3; i++) if (msg_ff[i] === 1'b1) pc[i]++;
	end
	// ==========================================================
	// Shared tasks
	// ==========================================================
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic bus(input logic [7:0] idx, input logic wr,
		input logic [7:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, wd};
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 40) begin
			err_total++;
			$display("Error waitrequest expected 0 seen 1");
			finish_test();
		end else begin
			@(posedge mclk);
		end
	endtask
	task automatic wr8(input logic [7:0] idx, d);
		logic [31:0] r;
		bus(idx, 1'b1, d, r);
	endtask
	task automatic rd8(input string nm, input logic [7:0] idx, exp);
		logic [31:0] r;
		bus(idx, 1'b0, 8'h0, r);
		chk(nm, {24'h0, exp}, r);
	endtask
	task automatic inj(input logic [1:0] e);
		ecc_err <= e;
		@(posedge mclk);
		ecc_err <= 2'h0;
		repeat (2) @(posedge mclk);
	endtask
	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_reset();
		rd8("first", REG_FIRST_IDX, 8'h0);
		rd8("next", REG_NEXT_IDX, 8'h0);
		for (int k = 0; k < 3; k++) rd8("enable", ena_idx(k), 8'h0);
		rd8("unmapped", 8'h84, 8'h0);
		avs_byteenable <= 4'he;
		wr8(REG_SERR_IDX, 8'h03);
		avs_byteenable <= 4'hf;
		rd8("lane off", REG_SERR_IDX, 8'h0);
		wr8(REG_SERR_IDX, 8'hff);
		rd8("reserved", REG_SERR_IDX, 8'h03);
		wr8(REG_SERR_IDX, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_log();
		inj(2'h3);
		rd8("first both", REG_FIRST_IDX, 8'h03);
		inj(2'h1);
		rd8("next corr", REG_NEXT_IDX, 8'h01);
		rd8("first held", REG_FIRST_IDX, 8'h03);
		inj(2'h2);
		rd8("next acc", REG_NEXT_IDX, 8'h03);
		rd8("first kept", REG_FIRST_IDX, 8'h03);
		wr8(REG_FIRST_IDX, 8'h00);
		rd8("w0 first", REG_FIRST_IDX, 8'h03);
		wr8(REG_FIRST_IDX, 8'h01);
		rd8("w1 first", REG_FIRST_IDX, 8'h02);
		wr8(REG_FIRST_IDX, 8'h02);
		wr8(REG_NEXT_IDX, 8'h03);
		rd8("w1 next", REG_NEXT_IDX, 8'h00);
		inj(2'h2);
		rd8("recapture", REG_FIRST_IDX, 8'h02);
		wr8(REG_FIRST_IDX, 8'h02);
		$display("test logging done");
	endtask
	task automatic t_msg();
		int b;
		for (int k = 0; k < 3; k++) begin
			b = 2 - k;
			wr8(ena_idx(k), 8'h01);
			for (int i = 0; i < 3; i++) pc[i] = 0;
			inj(2'h1);
			chk("pulse", 1, pc[b]);
			chk("pulse all", 1, pc[0] + pc[1] + pc[2]);
			inj(2'h1);
			chk("next pulse", 2, pc[b]);
			inj(2'h1);
			chk("no repeat", 2, pc[b]);
			wr8(ena_idx(k), 8'h02);
			inj(2'h2);
			chk("uncorr pulse", 3, pc[b]);
			chk("total", 3, pc[0] + pc[1] + pc[2]);
			wr8(REG_FIRST_IDX, 8'h03);
			wr8(REG_NEXT_IDX, 8'h03);
			wr8(ena_idx(k), 8'h00);
		end
		$display("test messages done");
	endtask
	task automatic t_rst2();
		inj(2'h3);
		inj(2'h1);
		wr8(REG_CTRL_EV_IDX, 8'h03);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		chk("wait in reset", 1, avs_waitrequest);
		chk("msg in reset", 0, msg_ff);
		rst <= 1'b0;
		@(posedge mclk);
		rd8("first rst", REG_FIRST_IDX, 8'h0);
		rd8("next rst", REG_NEXT_IDX, 8'h0);
		rd8("enable rst", REG_CTRL_EV_IDX, 8'h0);
		$display("test second reset done");
	endtask
	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		rst = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = 4'hf;
		ecc_err = 2'h0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_log();
		t_msg();
		t_rst2();
		finish_test();
	end
endmodule
`default_nettype wire

// file: dee_pkg.sv
// Package: register map, field layout and carrier types of the ECC error logger
`default_nettype none
package dee_pkg;
	// ==========================================================================
	// Register indices; byte address is four times the index
	// ==========================================================================
	localparam logic [7:0] REG_FIRST_IDX = 8'h80;
	localparam logic [7:0] REG_NEXT_IDX = 8'h82;
	localparam logic [7:0] REG_CTRL_EV_IDX = 8'h88;
	localparam logic [7:0] REG_MGMT_EV_IDX = 8'h8a;
	localparam logic [7:0] REG_SERR_IDX = 8'h8c;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	// ==========================================================================
	// Fields and reset values
	// ==========================================================================
	localparam int BIT_CORR = 0;
	localparam int BIT_UNCORR = 1;
	localparam int FLAG_W = 2;
	localparam logic [1:0] FLAGS_RST = 2'h0;
	localparam logic [1:0] ENA_RST = 2'h0;
	localparam logic [1:0] WORD_LO = 2'h0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

	// Errors reported by the memory controller in one cycle
	typedef struct packed {
		logic uncorr;
		logic corr;
	} dee_err_t;

	// Message outputs
	typedef struct packed {
		logic ctrl_ev;
		logic mgmt_ev;
		logic serr;
	} dee_msg_t;

	// Bus slave states (Gray along idle -> answer)
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_ANSWER = 1'b1
	} dee_bus_st_t;
endpackage
`default_nettype wire
